// >>> bench/scp_capture.sv
// Purpose: Capture side model
// Assumes: Stall request from bench
// Notes:   Released pins read as inverted word
`timescale 1ns/1ps
`default_nettype none
module scp_capture (
   input  wire logic       clk,
   input  wire logic       stall,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   output logic            ready,
   output logic [7:0]      pins
);
   assign ready = !stall;
   assign pins  = data_oe ? data_out : ~data_out;
endmodule // scp_capture
`default_nettype wire

// >>> bench/scp_properties.sv
// Purpose: Port checker for scp_top
// Assumes: One clock domain
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module scp_properties (
   input wire logic       CLK,
   input wire logic       RESET_N,
   input wire logic       OUTPUT_EN_N,
   input wire logic [7:0] DATA_OUT,
   input wire logic       DATA_OE,
   input wire logic       DATA_VALID,
   input wire logic       CAPTURE_READY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   AST_OE_ON: assert property (!OUTPUT_EN_N |-> DATA_OE) else $error("pins idle");
   AST_OE_OFF: assert property (OUTPUT_EN_N |-> !DATA_OE) else $error("pins driven");
   AST_FIRST: assert property ($rose(RESET_N) |-> (!DATA_VALID)[*3]) else $error("early");
   AST_LATENCY: assert property ($rose(RESET_N) ##0 CAPTURE_READY[*3] |-> ##1 DATA_VALID)
      else $error("late");
   AST_FLOW: assert property (CAPTURE_READY[*7] |-> DATA_VALID) else $error("no word");
   AST_CHANGE: assert property ($changed(DATA_OUT) |-> DATA_VALID) else $error("chg");
   AST_HOLD: assert property (DATA_VALID ##1 !DATA_VALID |-> $stable(DATA_OUT))
      else $error("lost");
   AST_STALL: assert property ((!CAPTURE_READY)[*2] |-> !DATA_VALID) else $error("stall");
   AST_RESUME: assert property (RESET_N[*8] ##1 !CAPTURE_READY ##1 CAPTURE_READY[*3]
      |-> DATA_VALID) else $error("stuck");
endmodule // scp_properties
bind scp_top scp_properties i_scp_properties (.CLK(CLK), .RESET_N(RESET_N),
   .OUTPUT_EN_N(OUTPUT_EN_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
   .DATA_VALID(DATA_VALID), .CAPTURE_READY(CAPTURE_READY));
`default_nettype wire

// >>> bench/scp_top_tb.sv
// Purpose: Self-checking bench for scp_top
// Assumes: Free running clock
// Notes:   One expected word queued per falling edge while out of reset
`timescale 1ns/1ps
`default_nettype none
module scp_top_tb;
   import scp_pkg::*;
   logic       clk = 0, rst_n = 0, below = 0, above = 0, oe_n = 0, stall = 0;
   logic [7:0] code = 0, pins, dout, exp;
   logic       doe, valid, ready;
   logic [7:0] q[$];
   logic [9:0] corner[6] = '{10'h000, 10'h0FF, 10'h080, 10'h17F, 10'h255, 10'h3AA};
   int         n_fail = 0, checks = 0, cyc = 0;
   localparam int LAT_Q = SCP_LAT_WHOLE + 1; // Samples in flight at mid-cycle
   logic       lat_chk = 1;
   scp_top i_scp_top (.CLK(clk), .RESET_N(rst_n), .SAMPLE_CODE(code),
      .BELOW_BOTTOM_REF(below), .ABOVE_TOP_REF(above), .OUTPUT_EN_N(oe_n),
      .DATA_OUT(dout), .DATA_OE(doe), .DATA_VALID(valid), .CAPTURE_READY(ready));
   scp_capture i_scp_capture (.clk(clk), .stall(stall), .data_out(dout),
      .data_oe(doe), .ready(ready), .pins(pins));
   initial forever #50 clk = ~clk;
   function automatic logic [7:0] expect_word(logic [7:0] c, logic b, logic a);
      return b ? SCP_CODE_ZERO : (a ? SCP_CODE_FULL : c);
   endfunction
   task automatic end_sim;
      if (n_fail == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic drive(logic [7:0] c, logic b, logic a);
      @(posedge clk);
      #1;
      code = c;
      below = b;
      above = a;
      oe_n = ($urandom % 4) == 0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 1500) begin
         n_fail++;
         end_sim();
      end
   end
   always @(negedge clk) begin
      if (rst_n && lat_chk) begin
         checks++;
         if (valid !== (q.size() >= LAT_Q)) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, valid, q.size() >= LAT_Q);
         end
      end
      if (valid === 1'b1) begin
         exp = oe_n ? ~q[0] : q[0];
         if (q.size() > 0) void'(q.pop_front());
         checks++;
         if (pins !== exp) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, pins, exp);
         end
      end
      if (rst_n) q.push_back(expect_word(code, below, above));
   end
   initial begin
      void'($urandom(32'h9d36));
      repeat (8) @(posedge clk);
      #1 rst_n = 1;
      foreach (corner[i]) drive(corner[i][7:0], corner[i][9], corner[i][8]);
      repeat (300) drive(8'($urandom), $urandom % 8 == 0, $urandom % 8 == 1);
      lat_chk = 0;
      stall = 1;
      repeat (6) drive(8'($urandom), 1'b0, 1'b0);
      stall = 0;
      repeat (300) drive(8'($urandom), $urandom % 8 == 0, $urandom % 8 == 1);
      end_sim();
   end
endmodule // scp_top_tb
`default_nettype wire

// >>> verilog/scp_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module scp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_r;
   logic [AW:0]      rd_r;
   wire              full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire              empty = (wr_r == rd_r);
   wire              push  = in_valid && !full;
   wire              pop   = out_ready && !empty;

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_r[rd_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end
endmodule // scp_fifo
`default_nettype wire

// >>> verilog/scp_pkg.sv
// Purpose: Constants for the sampled-converter output pipeline
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes:   Times in ns, cycle counts derived from the clock period
package scp_pkg;
   localparam int          SCP_WIDTH        = 8;
   localparam int          SCP_FIFO_DEPTH   = 8;
   localparam int          SCP_CLK_PERIOD_NS = 100;
   // Pipeline latency 2.5 cycles: half cycle from fall to rise plus 2 whole
   localparam int          SCP_LAT_WHOLE    = 2;
   localparam int          SCP_OUT_DELAY_NS = 16;
   localparam int          SCP_OUT_DELAY_CYC =
      ((SCP_OUT_DELAY_NS + SCP_CLK_PERIOD_NS - 1) / SCP_CLK_PERIOD_NS < 1) ? 1 :
      (SCP_OUT_DELAY_NS + SCP_CLK_PERIOD_NS - 1) / SCP_CLK_PERIOD_NS;
   localparam logic [7:0]  SCP_CODE_ZERO    = 8'h00;
   localparam logic [7:0]  SCP_CODE_FULL    = 8'hFF;
endpackage

// >>> verilog/scp_top.sv
// Purpose: Digital side of an 8-bit sampling converter output pipeline
// Assumes: Sample code arrives already quantised; clock runs continuously
// Notes:   Output drive is split into data, enable pins; no software registers
`timescale 1ns/1ps
`default_nettype none
module scp_top
   import scp_pkg::*;
#(
   parameter int WIDTH = SCP_WIDTH,
   parameter int DEPTH = SCP_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             RESET_N,
   // Quantiser front end
   input  wire logic [WIDTH-1:0] SAMPLE_CODE,
   input  wire logic             BELOW_BOTTOM_REF,
   input  wire logic             ABOVE_TOP_REF,
   // Output enable, active low
   input  wire logic             OUTPUT_EN_N,
   // Data pins
   output logic [WIDTH-1:0]      DATA_OUT,
   output logic                  DATA_OE,
   output logic                  DATA_VALID,
   input  wire logic             CAPTURE_READY
);
   import scp_pkg::*;

   // Codes forced at the rails
   localparam logic [WIDTH-1:0] ZERO_CODE   = SCP_CODE_ZERO[WIDTH-1:0];
   localparam logic [WIDTH-1:0] FULL_CODE   = {WIDTH{1'b1}};
   // Rising stages ahead of the buffer; the buffer write and the
   // output register make up the rest of the whole-cycle latency
   localparam int               PIPE_STAGES = SCP_LAT_WHOLE - 1;

   // Timing walk with the capture side ready:
   //   fall 0  sample taken into sample_r
   //   rise 1  sample moves into the first pipeline stage
   //   rise 2  last stage written into the buffer
   //   rise 3  word leaves the buffer into out_r, DATA_VALID high
   // Rise 3 is 2.5 cycles after fall 0; pin delay rides on top.
   // A stall holds words in the buffer while samples keep coming;
   // once the buffer is full the newest words are dropped.
   // The buffer write takes one of the two whole cycles, even while the capture side keeps up.

   // Saturation decode, straight binary
   // Below-bottom wins if both flags are raised at once
   wire             force_zero   = BELOW_BOTTOM_REF;
   wire             force_full   = !BELOW_BOTTOM_REF && ABOVE_TOP_REF;
   wire [WIDTH-1:0] clamped_code = force_zero ? ZERO_CODE :
                                   force_full ? FULL_CODE :
                                                SAMPLE_CODE;

   // Falling-edge sample stage; every fall, no start command
   // Reset is seen on the fall too, so a release just after a rise
   // lets the very next fall take the first sample
   logic [WIDTH-1:0] sample_r;
   logic [WIDTH-1:0] sample_nxt;
   logic             sample_vld_r;
   logic             sample_vld_nxt;
   assign sample_nxt     = RESET_N ? clamped_code : ZERO_CODE;
   assign sample_vld_nxt = RESET_N;

   always_ff @(negedge CLK) begin
      sample_r <= sample_nxt;
   end

   always_ff @(negedge CLK) begin
      sample_vld_r <= sample_vld_nxt;
   end

   // Rising-edge pipeline, one slice per stage
   logic [WIDTH-1:0] pipe_r   [PIPE_STAGES];
   logic             pipe_v_r [PIPE_STAGES];
   genvar g;
   generate
      for (g = 0; g < PIPE_STAGES; g++) begin : g_pipe
         wire [WIDTH-1:0] stage_in;
         wire             stage_v_in;
         if (g == 0) begin : g_head
            assign stage_in   = sample_r;
            assign stage_v_in = sample_vld_r;
         end else begin : g_tail
            assign stage_in   = pipe_r[g-1];
            assign stage_v_in = pipe_v_r[g-1];
         end
         always_ff @(posedge CLK) begin
            if (!RESET_N) begin
               pipe_r[g]   <= ZERO_CODE;
               pipe_v_r[g] <= 1'b0;
            end else begin
               pipe_r[g]   <= stage_in;
               pipe_v_r[g] <= stage_v_in;
            end
         end
      end
   endgenerate

   // Run state: the buffer takes words only once the pipeline is primed,
   // so nothing left over from before reset can slip into it
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FILL,
      ST_RUN
   } scp_run_t;
   scp_run_t run_r;
   scp_run_t run_nxt;

   always_comb begin
      run_nxt = run_r;
      case (run_r)
         ST_IDLE: begin
            run_nxt = ST_FILL;
         end
         ST_FILL: begin
            if (stage_last_v) begin
               run_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            run_nxt = ST_RUN;
         end
         default: begin
            run_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         run_r <= ST_IDLE;
      end else begin
         run_r <= run_nxt;
      end
   end

   // Buffer between the pipeline and the capture side
   // Its ready is left open: a stall longer than the buffer
   // depth loses the newest words, by design
   wire  [WIDTH-1:0] stage_last_d = pipe_r[PIPE_STAGES-1];
   wire              stage_last_v = pipe_v_r[PIPE_STAGES-1];
   wire              accept       = stage_last_v && (run_nxt == ST_RUN);
   logic             fifo_out_valid;
   logic [WIDTH-1:0] fifo_out_data;

   scp_fifo #(
      .WIDTH     (WIDTH),
      .DEPTH     (DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .in_valid  (accept),
      .in_ready  (),
      .in_data   (stage_last_d),
      .out_valid (fifo_out_valid),
      .out_ready (CAPTURE_READY),
      .out_data  (fifo_out_data)
   );

   // Output register: the word moves only at a rising edge and holds
   // until the next taken word, so the old word outlives the edge
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] out_nxt;
   logic             out_v_r;
   wire              take = fifo_out_valid && CAPTURE_READY;
   assign out_nxt = take ? fifo_out_data : out_r;

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         out_r <= ZERO_CODE;
      end else begin
         out_r <= out_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         out_v_r <= 1'b0;
      end else begin
         out_v_r <= take;
      end
   end

   // Pin drive, one slice per data bit
   // DATA_OE follows the enable pin directly, so the pins release
   // in the same cycle in which the enable rises
   logic [WIDTH-1:0] pin_data;
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_pin
         assign pin_data[b] = out_r[b];
      end
   endgenerate

   assign DATA_OE    = !OUTPUT_EN_N;
   assign DATA_OUT   = pin_data;
   assign DATA_VALID = out_v_r;
endmodule // scp_top
`default_nettype wire
